// >>> design/ubp_serial_boot.sv
`timescale 1ns/100ps
module ubp_serial_boot
    import ubp_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = TOUT_CYC_DEF,
    parameter logic [15:0] IRAM_TOP = IRAM_TOP_DEF
)(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // boot strap pins, asynchronous
    input wire logic [1:0] boot_select_pins,
    // received bytes from the uart, same clock
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_error,
    // bytes to the uart transmitter
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // internal ram write port
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    // control transfer and status
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic [1:0] boot_configuration_register_sel,
    output logic serial_mode,
    output logic retry_indicator_pin
);

    localparam logic [TOUT_W-1:0] TOUT_LAST = TOUT_W'(TOUT_CYCLES - 1);

    typedef struct packed {
        ubp_state_e st;
        ubp_state_e ret;
        ubp_msg_e msg;
        logic [2:0] midx;
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        logic [1:0] boot_cfg;
        logic serial;
        logic [16:0] cnt;
        logic [TOUT_W-1:0] tout;
        logic [31:0] acc;
        logic [31:0] crc_exp;
        logic [15:0] count;
        logic [15:0] addr;
        logic [3:0] hi;
        logic [7:0] sum;
        logic [31:0] crc;
        logic tx_valid;
        logic [7:0] tx_data;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic pc_load;
        logic retry;
    } ubp_state_s;

    localparam ubp_state_s RESET_STATE = '{
        st: S_POR, ret: S_POR, msg: M_ANNOUNCE, midx: 3'h0,
        sel_s1: BOOT_SEL_RESET, sel_s2: BOOT_SEL_RESET, boot_cfg: BOOT_SEL_RESET,
        serial: 1'b0, cnt: 17'h00000, tout: '0, acc: 32'h00000000,
        crc_exp: 32'h00000000, count: 16'h0000, addr: 16'h0000, hi: 4'h0,
        sum: 8'h00, crc: CRC_INIT, tx_valid: 1'b0, tx_data: 8'h00,
        mem_we: 1'b0, mem_addr: 16'h0000, mem_wdata: 8'h00, pc_load: 1'b0,
        retry: 1'b0
    };

    // ascii hex to {ok, nibble}
    function automatic logic [4:0] hex_nib(input logic [7:0] c);
        logic [4:0] v;
        v = 5'h00;
        if (c >= 8'h30 && c <= 8'h39)
        begin
            v = {1'b1, c[3:0]};
        end
        else if ((c >= 8'h61 && c <= 8'h66) || (c >= 8'h41 && c <= 8'h46))
        begin
            v = {1'b1, 4'(c[3:0] + 4'h9)};
        end
        return v;
    endfunction

    // one byte through the reflected crc32, lsb first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
        begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // message rom, character i of message id
    function automatic logic [7:0] msg_byte(input ubp_msg_e id, input logic [2:0] i);
        logic [63:0] m;
        logic [63:0] s;
        m = MSG_ANNOUNCE;
        case (id)
            M_ANNOUNCE: m = MSG_ANNOUNCE;
            M_BEGIN: m = MSG_BEGIN;
            M_DONE: m = MSG_DONE;
            M_BAD_ADDRESS: m = MSG_BAD_ADDRESS;
            M_BAD_COUNT: m = MSG_BAD_COUNT;
            M_CORRUPT: m = MSG_CORRUPT;
            default: m = MSG_ANNOUNCE;
        endcase
        s = m << {58'h0, i, 3'h0};
        return s[63:56];
    endfunction

    ubp_state_s r;
    ubp_state_s n;
    logic [4:0] nib;
    logic [31:0] acc;
    logic [7:0] bval;
    logic [7:0] sum;
    logic [31:0] crc;
    logic in_seq;
    logic restart;
    logic [16:0] img_end;
    logic [16:0] ram_end;

    // next-state logic for the whole protocol engine
    always_comb
    begin
        n = r;
        n.mem_we = 1'b0;
        n.pc_load = 1'b0;
        // strap synchroniser: second stage is the only reader of the first
        n.sel_s1 = boot_select_pins;
        n.sel_s2 = r.sel_s1;
        nib = hex_nib(rx_data);
        acc = {r.acc[27:0], nib[3:0]};
        bval = {r.hi, nib[3:0]};
        sum = r.sum + bval;
        crc = crc_byte(r.crc, bval);
        img_end = {r.count, 1'b0} - 17'h00001;
        ram_end = {1'b0, LOAD_BASE} + {1'b0, r.count};
        restart = 1'b0;
        in_seq = (r.st == S_ACK) || (r.st == S_HDR) || (r.st == S_TBL) || (r.st == S_IMG);
        if (in_seq)
        begin
            n.tout = r.tout + 1'b1;
        end
        case (r.st)
            S_POR:
            begin
                // wait for the synchroniser to settle after release
                n.cnt = r.cnt + 17'h00001;
                if (r.cnt[1:0] == SYNC_WAIT)
                begin
                    n.boot_cfg = r.sel_s2;
                    n.serial = (r.sel_s2 == BOOT_SEL_SERIAL);
                    n.st = (r.sel_s2 == BOOT_SEL_SERIAL) ? S_MSG : S_OTHER;
                    n.msg = M_ANNOUNCE;
                    n.ret = S_ACK;
                    n.midx = 3'h0;
                end
            end
            S_MSG:
            begin
                // one idle cycle between bytes keeps the handshake simple
                if (r.tx_valid && tx_ready)
                begin
                    n.tx_valid = 1'b0;
                    n.midx = r.midx + 3'h1;
                    if (r.midx == 3'h7)
                    begin
                        n.st = r.ret;
                        n.cnt = 17'h00000;
                        n.tout = '0;
                        n.sum = 8'h00;
                        n.crc = CRC_INIT;
                        n.pc_load = (r.ret == S_RUN);
                    end
                end
                else if (!r.tx_valid)
                begin
                    n.tx_valid = 1'b1;
                    n.tx_data = msg_byte(r.msg, r.midx);
                end
            end
            S_ACK:
            begin
                if (rx_valid)
                begin
                    n.cnt = r.cnt + 17'h00001;
                    if (rx_error)
                    begin
                        restart = 1'b1;
                    end
                    else if (rx_data != MSG_ACK[(7 - r.cnt[2:0]) * 8 +: 8])
                    begin
                        restart = 1'b1;
                    end
                    else if (r.cnt == ACK_LAST)
                    begin
                        n.st = S_HDR;
                        n.cnt = 17'h00000;
                    end
                end
            end
            S_HDR:
            begin
                if (rx_valid)
                begin
                    n.acc = acc;
                    n.cnt = r.cnt + 17'h00001;
                    if (rx_error || !nib[4])
                    begin
                        restart = 1'b1;
                    end
                    else if (r.cnt > HDR_ADR_LAST && nib[3:0] != 4'h0)
                    begin
                        restart = 1'b1; // trailing zero field must be zero
                    end
                    else if (r.cnt == HDR_CRC_LAST)
                    begin
                        n.crc_exp = acc;
                    end
                    else if (r.cnt == HDR_CNT_LAST)
                    begin
                        n.count = acc[15:0];
                    end
                    else if (r.cnt == HDR_ADR_LAST)
                    begin
                        n.addr = acc[15:0];
                    end
                    else if (r.cnt == HDR_LAST)
                    begin
                        n.st = S_MSG;
                        n.midx = 3'h0;
                        n.ret = S_RETRY;
                        if (r.addr < LOAD_BASE || r.addr >= IRAM_TOP)
                        begin
                            n.msg = M_BAD_ADDRESS;
                        end
                        else if (r.count == 16'h0000 || r.count[2:0] != 3'h0 ||
                                 ram_end > {1'b0, IRAM_TOP})
                        begin
                            n.msg = M_BAD_COUNT;
                        end
                        else
                        begin
                            n.msg = M_BEGIN;
                            n.ret = S_TBL;
                        end
                    end
                end
            end
            S_TBL:
            begin
                if (rx_valid)
                begin
                    n.cnt = r.cnt + 17'h00001;
                    if (rx_error || !nib[4])
                    begin
                        restart = 1'b1;
                    end
                    else if (!r.cnt[0])
                    begin
                        n.hi = nib[3:0];
                    end
                    else
                    begin
                        n.sum = sum;
                        if (r.cnt == TBL_LAST)
                        begin
                            n.st = S_MSG;
                            n.midx = 3'h0;
                            n.msg = (sum == SUM8_GOOD) ? M_DONE : M_CORRUPT;
                            n.ret = (sum == SUM8_GOOD) ? S_IMG : S_RETRY;
                        end
                    end
                end
            end
            S_IMG:
            begin
                if (rx_valid)
                begin
                    n.cnt = r.cnt + 17'h00001;
                    if (rx_error || !nib[4])
                    begin
                        restart = 1'b1;
                    end
                    else if (!r.cnt[0])
                    begin
                        n.hi = nib[3:0];
                    end
                    else
                    begin
                        n.crc = crc;
                        n.mem_we = 1'b1;
                        n.mem_addr = LOAD_BASE + r.cnt[16:1];
                        n.mem_wdata = bval;
                        if (r.cnt == img_end)
                        begin
                            n.st = S_MSG;
                            n.midx = 3'h0;
                            n.msg = ((~crc) == r.crc_exp) ? M_DONE : M_CORRUPT;
                            n.ret = ((~crc) == r.crc_exp) ? S_RUN : S_RETRY;
                        end
                    end
                end
            end
            S_RETRY:
            begin
                restart = 1'b1;
            end
            S_OTHER:
            begin
                n.st = S_OTHER; // another boot mode owns the device
            end
            S_RUN:
            begin
                n.st = S_RUN; // control has passed to the loaded image
            end
            default:
            begin
                n.st = S_POR;
            end
        endcase
        // a one-shot per sequence, not re-armed by each byte
        if (in_seq && r.tout == TOUT_LAST)
        begin
            restart = 1'b1;
        end
        if (restart)
        begin
            n.st = S_MSG;
            n.msg = M_ANNOUNCE;
            n.ret = S_ACK;
            n.midx = 3'h0;
            n.tx_valid = 1'b0;
            n.mem_we = 1'b0;
            n.retry = ~r.retry;
        end
    end

    // the only state register; ce low freezes everything except rst, which still loads the reset state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r <= RESET_STATE;
        end
        else if (ce)
        begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign tx_valid = r.tx_valid;
    assign tx_data = r.tx_data;
    assign mem_we = r.mem_we;
    assign mem_addr = r.mem_addr;
    assign mem_wdata = r.mem_wdata;
    assign pc_load = r.pc_load;
    assign pc_value = r.addr;
    assign boot_configuration_register_sel = r.boot_cfg;
    assign serial_mode = r.serial;
    assign retry_indicator_pin = r.retry;

endmodule // ubp_serial_boot

// >>> design/ubp_pkg.sv
package ubp_pkg;

    // clock and serial framing figures
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned UART_BAUD = 115_200;
    localparam int unsigned UART_DATA_BITS = 8;
    localparam int unsigned UART_STOP_BITS = 1;
    localparam bit UART_PARITY_EN = 1'b0;

    // one-shot receive timeout, in ms and in cycles
    localparam int unsigned TOUT_MS = 500;
    localparam int unsigned TOUT_CYC_DEF = TOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned TOUT_W = 23;

    // boot select decoding
    localparam logic [1:0] BOOT_SEL_SERIAL = 2'h3;
    localparam logic [1:0] BOOT_SEL_RESET = 2'h0;
    localparam logic [1:0] SYNC_WAIT = 2'h2;

    // internal ram layout
    localparam logic [15:0] LOAD_BASE = 16'h0100;
    localparam logic [15:0] OTHER_LOAD_BASE = 16'h0020;
    localparam logic [15:0] IRAM_TOP_DEF = 16'h7800;

    // receive sequence lengths, in characters, last index
    localparam logic [16:0] ACK_LAST = 17'h00007;
    localparam logic [16:0] HDR_CRC_LAST = 17'h00007;
    localparam logic [16:0] HDR_CNT_LAST = 17'h0000b;
    localparam logic [16:0] HDR_ADR_LAST = 17'h0000f;
    localparam logic [16:0] HDR_LAST = 17'h00013;
    localparam logic [16:0] TBL_LAST = 17'h007ff;

    // crc32, reflected form of the given generator polynomial
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [7:0] SUM8_GOOD = 8'h00;

    // eight-byte messages, first character in the top byte
    localparam logic [63:0] MSG_ANNOUNCE = 64'h20424f4f544d4500;
    localparam logic [63:0] MSG_ACK = 64'h2020202041434b00;
    localparam logic [63:0] MSG_BEGIN = 64'h2020424547494e00;
    localparam logic [63:0] MSG_DONE = 64'h20204d444f4e4500;
    localparam logic [63:0] MSG_BAD_ADDRESS = 64'h4241444144445200;
    localparam logic [63:0] MSG_BAD_COUNT = 64'h20424144434e5400;
    localparam logic [63:0] MSG_CORRUPT = 64'h434f525255505400;

    typedef enum logic [2:0] {
        M_ANNOUNCE,
        M_BEGIN,
        M_DONE,
        M_BAD_ADDRESS,
        M_BAD_COUNT,
        M_CORRUPT
    } ubp_msg_e;

    typedef enum logic [3:0] {
        S_POR,
        S_OTHER,
        S_MSG,
        S_ACK,
        S_HDR,
        S_TBL,
        S_IMG,
        S_RETRY,
        S_RUN
    } ubp_state_e;

endpackage

// >>> verif/ubp_serial_boot_assertions.sv
`timescale 1ns/100ps
// port-level checks of the serial boot engine
module ubp_serial_boot_assertions
    import ubp_pkg::*;
#(
    parameter int unsigned TOUT_CYCLES = TOUT_CYC_DEF,
    parameter logic [15:0] IRAM_TOP = IRAM_TOP_DEF
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial byte side
    input wire logic rx_valid,
    input wire logic rx_error,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    // memory and control
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic [1:0] boot_configuration_register_sel,
    input wire logic serial_mode,
    input wire logic retry_indicator_pin
);
    // one domain, so one clock and one disable serve every property
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // a faulty byte seen while the device listens
    sequence rx_fault;
        serial_mode && rx_valid && rx_error && !tx_valid;
    endsequence

    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte changed before acceptance");
    a_tx_release: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("tx valid held after acceptance");
    a_mode_sel: assert property (
        serial_mode |-> boot_configuration_register_sel == 2'h3)
        else $error("serial mode without strap 11");
    a_quiet_other: assert property (!serial_mode |-> !tx_valid)
        else $error("transmit outside serial boot");
    a_first_announce: assert property (
        $rose(serial_mode) |-> ##[0:3] (tx_valid && tx_data == 8'h20))
        else $error("no announce after strap latch");
    a_err_restart: assert property (
        rx_fault |-> ##[1:4] (tx_valid && tx_data == 8'h20))
        else $error("bad byte did not restart");
    a_err_retry: assert property (rx_fault |-> ##[1:4] $changed(retry_indicator_pin))
        else $error("retry pin did not toggle");
    a_mem_window: assert property (
        mem_we |-> mem_addr >= 16'h0100 && mem_addr < IRAM_TOP)
        else $error("image write outside load window");
    a_jump_after: assert property (
        pc_load |-> $past(tx_valid && tx_ready && tx_data == 8'h00))
        else $error("jump not right after done message");
    a_jump_entry: assert property (
        pc_load |-> pc_value >= 16'h0100 && pc_value < IRAM_TOP)
        else $error("jump to invalid entry");
    a_jump_pulse: assert property (pc_load |=> !pc_load)
        else $error("jump pulse longer than one cycle");

    // main scenarios reached
    c_write: cover property (mem_we);
    c_jump: cover property (pc_load);
    c_fault: cover property (rx_fault);
endmodule // ubp_serial_boot_assertions

bind ubp_serial_boot ubp_serial_boot_assertions #(
    .TOUT_CYCLES(TOUT_CYCLES), .IRAM_TOP(IRAM_TOP)
) u_chk (
    .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_error(rx_error),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .mem_we(mem_we), .mem_addr(mem_addr), .pc_load(pc_load), .pc_value(pc_value),
    .boot_configuration_register_sel(boot_configuration_register_sel),
    .serial_mode(serial_mode), .retry_indicator_pin(retry_indicator_pin)
);

// >>> verif/ubp_host_model.sv
`timescale 1ns/100ps
// host utility stand-in: takes device bytes, sends ascii characters
module ubp_host_model (
    // clock
    input wire logic clk,
    // device transmit side
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // device receive side
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_error
);
    logic [7:0] got_q[$];
    int lag = 0;
    int held = 0;

    // quiet lines at time zero
    initial
    begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_error = 1'b0;
    end

    // collect each byte the device hands over
    always @(posedge clk)
        if (tx_valid && tx_ready)
            got_q.push_back(tx_data);

    // ready only after lag cycles, so a slow host is exercised too
    always @(negedge clk)
    begin
        tx_ready <= tx_valid && (held >= lag);
        held <= tx_valid ? held + 1 : 0;
    end

    // one pulse per character; data is scrambled once the pulse ends
    // spacing is far below the host's millisecond gaps, to keep runs short
    task automatic send_char(input logic [7:0] c, input logic err);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = c;
        rx_error = err;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_error = 1'b0;
        rx_data = ~c;
    endtask

    // plain text, no terminator
    task automatic send_txt(input string s);
        for (int i = 0; i < s.len(); i++)
            send_char(s[i], 1'b0);
    endtask

    // value as n hex digits, most significant first
    task automatic send_hex(input logic [31:0] v, input int n, input logic up);
        logic [7:0] d;
        for (int i = n - 1; i >= 0; i--)
        begin
            d = {4'h0, v[4*i +: 4]};
            send_char(d < 8'h0a ? 8'h30 + d : (up ? 8'h37 : 8'h57) + d, 1'b0);
        end
    endtask
endmodule // ubp_host_model

// >>> verif/test_ubp_serial_boot.sv
`timescale 1ns/100ps
`define CHECK_EQ(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("[FAIL] %s exp %0h got %0h", what, exp, got); \
        end \
    end

module test_ubp_serial_boot
    import ubp_pkg::*;
;
    localparam int unsigned TOUT = 8000;
    // expected replies, first character in the top byte, null last
    localparam logic [63:0] EXP_ANNOUNCE = 64'h20424f4f544d4500;
    localparam logic [63:0] EXP_BEGIN = 64'h2020424547494e00;
    localparam logic [63:0] EXP_DONE = 64'h20204d444f4e4500;
    localparam logic [63:0] EXP_BAD_ADDR = 64'h4241444144445200;
    localparam logic [63:0] EXP_BAD_CNT = 64'h20424144434e5400;
    localparam logic [63:0] EXP_CORRUPT = 64'h434f525255505400;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [1:0] boot_select_pins = 2'h0;
    logic rx_valid, rx_error, tx_valid, tx_ready, mem_we, pc_load;
    logic serial_mode, retry_indicator_pin;
    logic [7:0] rx_data, tx_data, mem_wdata, b;
    logic [15:0] mem_addr, pc_value, pc_seen;
    logic [1:0] boot_configuration_register_sel;
    logic [15:0] addr_q[$];
    logic [7:0] data_q[$];
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int pc_n = 0;

    always #50 clk = ~clk;

    // record image writes and jumps
    always @(posedge clk)
    begin
        cyc++;
        if (mem_we === 1'b1)
        begin
            addr_q.push_back(mem_addr);
            data_q.push_back(mem_wdata);
        end
        if (pc_load === 1'b1)
        begin
            pc_n++;
            pc_seen = pc_value;
        end
    end

    ubp_serial_boot #(.TOUT_CYCLES(TOUT), .IRAM_TOP(IRAM_TOP_DEF)) dut (
        .clk(clk), .rst(rst), .ce(ce), .boot_select_pins(boot_select_pins),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .pc_load(pc_load), .pc_value(pc_value),
        .boot_configuration_register_sel(boot_configuration_register_sel),
        .serial_mode(serial_mode), .retry_indicator_pin(retry_indicator_pin));
    ubp_host_model host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // bounded wait for device bytes; running out ends the run
    task automatic wait_tx(input int need, input int lim);
        int k = 0;
        while (host.got_q.size() < need && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= lim)
        begin
            num_errors++;
            $display("[FAIL] tx wait exp %0d got %0d", need, host.got_q.size());
            print_verdict();
        end
    endtask

    // seven text characters then the null terminator
    task automatic expect_msg(input logic [63:0] m);
        wait_tx(8, 20000);
        for (int i = 0; i < 8; i++)
        begin
            b = host.got_q.pop_front();
            `CHECK_EQ("msg_byte", m[8*(7-i) +: 8], b)
        end
    endtask

    task automatic do_reset(input logic [1:0] pins);
        @(negedge clk);
        rst = 1'b1;
        boot_select_pins = pins;
        repeat (5) @(negedge clk);
        rst = 1'b0;
    endtask

    function automatic logic [7:0] img(input int i);
        return 8'(i * 37 + 11);
    endfunction

    // reflected crc32, all-ones start, inverted result
    function automatic logic [31:0] crc_img();
        logic [31:0] c = 32'hffffffff;
        for (int i = 0; i < 8; i++)
        begin
            c = c ^ {24'h0, img(i)};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        return ~c;
    endfunction

    task automatic send_head(input logic [31:0] crc, input logic [15:0] cnt, input logic [15:0] adr);
        host.send_txt("    ACK");
        host.send_char(8'h00, 1'b0);
        host.send_hex(crc, 8, 1'b0);
        host.send_hex({16'h0, cnt}, 4, 1'b1);
        host.send_hex({16'h0, adr}, 4, 1'b0);
        host.send_hex(32'h0, 4, 1'b0);
    endtask

    // bytes 0..255 four times sum to zero; fix spoils the last one
    task automatic send_table(input logic [7:0] fix);
        for (int i = 0; i < 1024; i++)
            host.send_hex({24'h0, 8'(i) + (i == 1023 ? fix : 8'h00)}, 2, 1'b1);
    endtask

    // strap 10 must be latched but must not start the serial engine
    task automatic t_other_mode();
        do_reset(2'h2);
        repeat (40) @(negedge clk);
        `CHECK_EQ("serial_mode", 1'b0, serial_mode)
        `CHECK_EQ("boot_cfg", 2'h2, boot_configuration_register_sel)
        `CHECK_EQ("tx_count", 0, host.got_q.size())
    endtask

    // a frozen engine neither latches the strap nor speaks
    task automatic t_announce();
        do_reset(2'h3);
        ce = 1'b0;
        repeat (20) @(negedge clk);
        `CHECK_EQ("frozen_mode", 1'b0, serial_mode)
        `CHECK_EQ("frozen_tx", 0, host.got_q.size())
        ce = 1'b1;
        expect_msg(EXP_ANNOUNCE);
        `CHECK_EQ("serial_mode", 1'b1, serial_mode)
        `CHECK_EQ("boot_cfg", 2'h3, boot_configuration_register_sel)
    endtask

    task automatic t_bad_ack();
        logic r0 = retry_indicator_pin;
        host.lag = 3;
        host.send_txt("    ACX");
        host.send_char(8'h00, 1'b0);
        expect_msg(EXP_ANNOUNCE);
        `CHECK_EQ("retry_pin", ~r0, retry_indicator_pin)
        host.lag = 0;
    endtask

    task automatic t_rx_error();
        host.send_txt("  ");
        host.send_char(8'h20, 1'b1);
        expect_msg(EXP_ANNOUNCE);
    endtask

    // a non-hex character in the header ends the session
    task automatic t_bad_hex();
        logic r0 = retry_indicator_pin;
        host.send_txt("    ACK");
        host.send_char(8'h00, 1'b0);
        host.send_char(8'h67, 1'b0);
        expect_msg(EXP_ANNOUNCE);
        `CHECK_EQ("retry_pin", ~r0, retry_indicator_pin)
    endtask

    task automatic t_timeout();
        int t0 = cyc;
        wait_tx(1, TOUT + 200);
        `CHECK_EQ("tout_span", 1'b1, (cyc - t0 >= TOUT - 5) && (cyc - t0 <= TOUT + 20))
        expect_msg(EXP_ANNOUNCE);
    endtask

    task automatic t_bad_addr();
        send_head(crc_img(), 16'h0008, 16'h0010);
        expect_msg(EXP_BAD_ADDR);
        expect_msg(EXP_ANNOUNCE);
    endtask

    task automatic t_bad_cnt();
        send_head(crc_img(), 16'h0007, 16'h0140);
        expect_msg(EXP_BAD_CNT);
        expect_msg(EXP_ANNOUNCE);
    endtask

    task automatic t_bad_table();
        send_head(crc_img(), 16'h0008, 16'h0140);
        expect_msg(EXP_BEGIN);
        send_table(8'h01);
        expect_msg(EXP_CORRUPT);
        expect_msg(EXP_ANNOUNCE);
    endtask

    // image sent whole, as raw bytes in lower-case hex
    task automatic load_image(input logic [31:0] crc);
        addr_q.delete();
        data_q.delete();
        send_head(crc, 16'h0008, 16'h0140);
        expect_msg(EXP_BEGIN);
        send_table(8'h00);
        expect_msg(EXP_DONE);
        for (int i = 0; i < 8; i++)
            host.send_hex({24'h0, img(i)}, 2, 1'b0);
    endtask

    task automatic t_bad_image();
        load_image(crc_img() ^ 32'h00000001);
        expect_msg(EXP_CORRUPT);
        expect_msg(EXP_ANNOUNCE);
        `CHECK_EQ("jumps", 0, pc_n)
    endtask

    task automatic t_good();
        load_image(crc_img());
        expect_msg(EXP_DONE);
        repeat (4) @(negedge clk);
        `CHECK_EQ("jumps", 1, pc_n)
        `CHECK_EQ("entry", 16'h0140, pc_seen)
        `CHECK_EQ("writes", 8, addr_q.size())
        for (int i = 0; i < 8 && i < addr_q.size(); i++)
        begin
            `CHECK_EQ("mem_addr", 16'(16'h0100 + i), addr_q[i])
            `CHECK_EQ("mem_wdata", img(i), data_q[i])
        end
    endtask

    initial
    begin
        t_other_mode();
        t_announce();
        t_bad_ack();
        t_rx_error();
        t_bad_hex();
        t_timeout();
        t_bad_addr();
        t_bad_cnt();
        t_bad_table();
        t_bad_image();
        t_good();
        print_verdict();
    end
endmodule // test_ubp_serial_boot
